/* logic/e1_national_bits_alarm_integrator.sv */
// e1 receive back end: national bits, link id and alarm integration
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
// How it works
// - gather a four-bit submultiframe codeword for each of Sa4 to Sa8
// - copy codewords to holding values only on the submultiframe event
// - set link id when two of the last three Sa7 bits are zero
// - clear link id when two of the last three Sa7 bits are one
// - declare each alarm only after roughly 100 ms of defect
// - withdraw each alarm only after roughly 100 ms without defect
// - interval is valid AIS when 13 of 16 detect samples are set
// - AIS counter rises per valid interval; alarm declared at 25
// - AIS counter falls per other interval; alarm removed at 0
// - interval is out of frame if loss indication seen at all
// - interval is in frame only if loss indication never seen
// - Red counter rises per out-of-frame interval; alarm at 25
// - Red counter falls per in-frame interval; removed at 0
// - all-ones detect comes from the framer's 512-bit zero count
// - loss indication comes from three bad alignment words in a row
module e1_national_bits_alarm_integrator
  import nb_alarm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer stream and defects
  input wire logic line_bit_en,
  input wire logic all_ones_defect_detect,
  input wire logic frame_loss_indication,
  input wire logic sa_strobe,
  input wire logic [SA_COUNT-1:0] sa_bits,
  input wire logic [SA_POS_W-1:0] sa_pos,
  input wire logic submf_end,
  // alarms and interrupt
  output logic link_id_detected,
  output logic red_alarm,
  output logic ais_alarm,
  output logic irq
);
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_INT_STAT = 3'h1;
  localparam logic [2:0] IDX_INT_MASK = 3'h2;
  localparam logic [2:0] IDX_CTRL = 3'h3;
  localparam logic [2:0] IDX_NATBITS = 3'h4;
  localparam logic [2:0] IDX_COUNTS = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  typedef struct packed {
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [AIS_HIT_W-1:0] ais_hits;
    logic oof_seen;
    logic [LINK_VOTE_LEN-1:0] sa7_hist;
    logic link_id;
    logic red_prev;
    logic ais_prev;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic integ_en;
    logic [31:0] rdata;
  } state_s;

  // sa7 history starts at all ones so link id is clear out of reset
  localparam state_s STATE_RST = '{
    bit_cnt: '0,
    ais_hits: '0,
    oof_seen: 1'b0,
    sa7_hist: SA7_HIST_RST,
    link_id: 1'b0,
    red_prev: 1'b0,
    ais_prev: 1'b0,
    int_stat: '0,
    int_mask: INT_MASK_RST,
    integ_en: CTRL_EN_RST,
    rdata: '0
  };

  state_s s_q;
  state_s s_d;

  logic interval_end;
  logic ais_valid;
  logic oof_interval;
  logic [ALARM_CNT_W-1:0] red_count;
  logic [ALARM_CNT_W-1:0] ais_count;
  logic [SA_COUNT*CODEWORD_BITS-1:0] codewords;

  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    if (addr == OFS_STATUS) begin
      reg_index = IDX_STATUS;
    end else if (addr == OFS_INT_STAT) begin
      reg_index = IDX_INT_STAT;
    end else if (addr == OFS_INT_MASK) begin
      reg_index = IDX_INT_MASK;
    end else if (addr == OFS_CTRL) begin
      reg_index = IDX_CTRL;
    end else if (addr == OFS_NATBITS) begin
      reg_index = IDX_NATBITS;
    end else if (addr == OFS_COUNTS) begin
      reg_index = IDX_COUNTS;
    end else begin
      reg_index = IDX_NONE;
    end
  endfunction

  // three-bit vote, so there is never a tie
  function automatic logic zero_majority(input logic [LINK_VOTE_LEN-1:0] h);
    logic [1:0] zeros;
    zeros = '0;
    for (int i = 0; i < LINK_VOTE_LEN; i++) begin
      zeros = zeros + 2'(!h[i]);
    end
    zero_majority = zeros >= 2'(LINK_VOTE_MIN);
  endfunction

  // register read mux; unmapped offsets read as zero
  function automatic logic [31:0] read_word(
    input logic [2:0] i,
    input state_s s,
    input logic red,
    input logic ais,
    input logic [SA_COUNT*CODEWORD_BITS-1:0] cw,
    input logic [ALARM_CNT_W-1:0] rc,
    input logic [ALARM_CNT_W-1:0] ac
  );
    read_word = '0;
    if (i == IDX_STATUS) begin
      read_word[ST_LINK_BIT] = s.link_id;
      read_word[ST_RED_BIT] = red;
      read_word[ST_AIS_BIT] = ais;
    end else if (i == IDX_INT_STAT) begin
      read_word[INT_W-1:0] = s.int_stat;
    end else if (i == IDX_INT_MASK) begin
      read_word[INT_W-1:0] = s.int_mask;
    end else if (i == IDX_CTRL) begin
      read_word[0] = s.integ_en;
    end else if (i == IDX_NATBITS) begin
      read_word[SA_COUNT*CODEWORD_BITS-1:0] = cw;
    end else if (i == IDX_COUNTS) begin
      read_word[CNT_RED_LSB +: ALARM_CNT_W] = rc;
      read_word[CNT_AIS_LSB +: ALARM_CNT_W] = ac;
    end
  endfunction

  nat_bit_collector u_collect (
    .clk(clk),
    .srst(srst),
    .sa_strobe(sa_strobe),
    .sa_bits(sa_bits),
    .sa_pos(sa_pos),
    .submf_end(submf_end),
    .codewords(codewords)
  );

  // disabling integration clears both counters and drops both alarms
  // Red interval integration
  alarm_integrator #(
    .MAX_COUNT(ALARM_INTERVALS),
    .CW(ALARM_CNT_W)
  ) u_red (
    .clk(clk),
    .srst(srst),
    .clear(!s_q.integ_en),
    .tick(interval_end),
    .hit(oof_interval),
    .count(red_count),
    .alarm(red_alarm)
  );

  alarm_integrator #(
    .MAX_COUNT(ALARM_INTERVALS),
    .CW(ALARM_CNT_W)
  ) u_ais (
    .clk(clk),
    .srst(srst),
    .clear(!s_q.integ_en),
    .tick(interval_end),
    .hit(ais_valid),
    .count(ais_count),
    .alarm(ais_alarm)
  );

  always_comb begin
    logic [2:0] idx;
    logic ais_sample;
    logic [AIS_HIT_W-1:0] hits_now;
    logic oof_now;
    logic [LINK_VOTE_LEN-1:0] hist;
    logic [INT_W-1:0] set_ev;
    logic [INT_W-1:0] clr;

    idx = reg_index(paddr);
    ais_sample = 1'b0;
    hits_now = '0;
    oof_now = 1'b0;
    hist = '0;
    set_ev = '0;
    clr = '0;
    s_d = s_q;

    // interval timing runs off the line bit rate, 8192 bits per 4 ms
    interval_end = line_bit_en && (s_q.bit_cnt == BIT_CNT_W'(BITS_PER_INTERVAL - 1));
    if (line_bit_en) begin
      s_d.bit_cnt = s_q.bit_cnt + BIT_CNT_W'(1);
    end

    // the closing window's sample still counts toward its own interval
    // one detect sample per 512-bit window
    ais_sample = line_bit_en && (s_q.bit_cnt[AIS_WIN_W-1:0] == '1);
    // detect level is the framer's 512-bit zero-count result
    hits_now = s_q.ais_hits + AIS_HIT_W'(ais_sample && all_ones_defect_detect);
    // 13 of 16 samples make a valid AIS interval
    ais_valid = hits_now >= AIS_HIT_W'(AIS_VALID_MIN);

    // loss indication is watched every cycle, not just per bit
    oof_now = s_q.oof_seen | frame_loss_indication;
    // any occurrence marks the interval out of frame
    oof_interval = oof_now;
    // in-frame interval is the complement over the whole interval
    if (interval_end) begin
      s_d.ais_hits = '0;
      s_d.oof_seen = 1'b0;
    end else begin
      s_d.ais_hits = hits_now;
      s_d.oof_seen = oof_now;
    end

    // sa7 history only moves on a qualifying frame
    hist = s_q.sa7_hist;
    if (sa_strobe) begin
      hist = {s_q.sa7_hist[LINK_VOTE_LEN-2:0], sa_bits[SA7_IDX]};
    end
    s_d.sa7_hist = hist;
    // majority of zeros raises link id
    if (zero_majority(hist)) begin
      s_d.link_id = 1'b1;
    end else begin
      s_d.link_id = 1'b0;
    end

    // change events lag the alarm by a cycle, off registered copies
    s_d.red_prev = red_alarm;
    s_d.ais_prev = ais_alarm;
    // submultiframe interrupt coincides with the holding copy
    set_ev[INT_SUBMF_BIT] = submf_end;
    set_ev[INT_LINK_BIT] = s_d.link_id != s_q.link_id;
    set_ev[INT_RED_BIT] = red_alarm != s_q.red_prev;
    set_ev[INT_AIS_BIT] = ais_alarm != s_q.ais_prev;

    // write takes effect at the access edge; pready is high in every access phase
    if (psel && penable && pwrite) begin
      if (idx == IDX_INT_STAT) begin
        clr = pwdata[INT_W-1:0];
      end else if (idx == IDX_INT_MASK) begin
        s_d.int_mask = pwdata[INT_W-1:0];
      end else if (idx == IDX_CTRL) begin
        s_d.integ_en = pwdata[0];
      end
    end
    // a new event beats a same-cycle clear
    s_d.int_stat = (s_q.int_stat & ~clr) | set_ev;

    // read data is captured in the setup cycle so it comes from a flop
    if (psel && !penable) begin
      s_d.rdata = read_word(idx, s_q, red_alarm, ais_alarm, codewords, red_count, ais_count);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // 25 intervals of 4 ms give the declaration time
  // draining from 25 to 0 gives the removal time
  // AIS removal at zero is handled in the integrator
  // Red removal at zero is handled in the integrator
  // saturation lives in the integrator counters
  assign pready = psel && penable;
  // unmapped offsets still complete at once, flagged as an error
  assign pslverr = psel && penable && (reg_index(paddr) == IDX_NONE);
  assign prdata = s_q.rdata;
  assign link_id_detected = s_q.link_id;
  // a level: drops as soon as software clears or masks the cause
  assign irq = |(s_q.int_stat & s_q.int_mask);
endmodule

/* logic/nb_alarm_pkg.sv */
// constants for the national-bit extractor and alarm integrator
package nb_alarm_pkg;
  // line timing
  localparam int LINE_RATE_KHZ = 2048;
  localparam int INTERVAL_US = 4000;
  localparam int BITS_PER_INTERVAL = INTERVAL_US * LINE_RATE_KHZ / 1000;
  localparam int BIT_CNT_W = $clog2(BITS_PER_INTERVAL);
  localparam int AIS_WINDOW_BITS = 512;
  localparam int AIS_WIN_W = $clog2(AIS_WINDOW_BITS);
  localparam int AIS_SAMPLES = BITS_PER_INTERVAL / AIS_WINDOW_BITS;
  localparam int AIS_HIT_W = $clog2(AIS_SAMPLES + 1);
  localparam int AIS_VALID_MIN = 13;
  localparam int ALARM_INTERVALS = 25;
  localparam int ALARM_CNT_W = 5;
  // national bits
  localparam int SA_COUNT = 5;
  localparam int CODEWORD_BITS = 4;
  localparam int SA_POS_W = 2;
  localparam int SA7_IDX = 3;
  localparam int LINK_VOTE_LEN = 3;
  localparam int LINK_VOTE_MIN = 2;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_INT_STAT = 8'h04;
  localparam logic [7:0] OFS_INT_MASK = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_NATBITS = 8'h10;
  localparam logic [7:0] OFS_COUNTS = 8'h14;
  // status bit positions
  localparam int ST_LINK_BIT = 0;
  localparam int ST_RED_BIT = 1;
  localparam int ST_AIS_BIT = 2;
  // interrupt bit positions
  localparam int INT_W = 4;
  localparam int INT_SUBMF_BIT = 0;
  localparam int INT_LINK_BIT = 1;
  localparam int INT_RED_BIT = 2;
  localparam int INT_AIS_BIT = 3;
  // counts field positions
  localparam int CNT_RED_LSB = 0;
  localparam int CNT_AIS_LSB = 8;
  // reset values
  localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [LINK_VOTE_LEN-1:0] SA7_HIST_RST = 3'h7;
endpackage

/* logic/alarm_integrator.sv */
// up/down interval counter with saturating alarm declaration
`timescale 1ns/100ps
module alarm_integrator
  import nb_alarm_pkg::*;
#(
  parameter int MAX_COUNT = ALARM_INTERVALS,
  parameter int CW = ALARM_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // interval results
  input wire logic clear,
  input wire logic tick,
  input wire logic hit,
  // results
  output logic [CW-1:0] count,
  output logic alarm
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic alarm;
  } integ_s;

  localparam logic [CW-1:0] TOP = CW'(MAX_COUNT);

  integ_s s_q;
  integ_s s_d;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d = '0;
    end else if (tick) begin
      // saturate both ways so a long defect cannot wrap the count
      if (hit && s_q.cnt != TOP) begin
        s_d.cnt = s_q.cnt + CW'(1);
      end else if (!hit && s_q.cnt != '0) begin
        s_d.cnt = s_q.cnt - CW'(1);
      end
      // alarm keeps its value between the two end points
      if (s_d.cnt == TOP) begin
        s_d.alarm = 1'b1;
      end else if (s_d.cnt == '0) begin
        s_d.alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign alarm = s_q.alarm;
endmodule

/* logic/nat_bit_collector.sv */
// assembles the five national-bit codewords per submultiframe
`timescale 1ns/100ps
module nat_bit_collector
  import nb_alarm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // framer national bits
  input wire logic sa_strobe,
  input wire logic [SA_COUNT-1:0] sa_bits,
  input wire logic [SA_POS_W-1:0] sa_pos,
  input wire logic submf_end,
  // holding values
  output logic [SA_COUNT*CODEWORD_BITS-1:0] codewords
);
  localparam int CWW = SA_COUNT * CODEWORD_BITS;

  typedef struct packed {
    logic [CWW-1:0] work;
    logic [CWW-1:0] hold;
  } coll_s;

  coll_s s_q;
  coll_s s_d;

  always_comb begin
    s_d = s_q;
    if (sa_strobe) begin
      // bit 1 of each codeword lands in its msb
      for (int i = 0; i < SA_COUNT; i++) begin
        s_d.work[i*CODEWORD_BITS + (CODEWORD_BITS-1) - int'(sa_pos)] = sa_bits[i];
      end
    end
    // copy only on the submultiframe event, including a bit taken this cycle
    if (submf_end) begin
      s_d.hold = s_d.work;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign codewords = s_q.hold;
endmodule

/* verif/nb_alarm_props.sv */
// port checks for the national-bit and alarm block
`timescale 1ns/100ps
module nb_alarm_props
  import nb_alarm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // framer side and results
  input wire logic line_bit_en,
  input wire logic sa_strobe,
  input wire logic [SA_COUNT-1:0] sa_bits,
  input wire logic link_id_detected,
  input wire logic red_alarm,
  input wire logic ais_alarm,
  input wire logic irq
);
  localparam int LIM = ALARM_INTERVALS * BITS_PER_INTERVAL;
  typedef struct packed {
    logic [2:0] hist;
    logic [17:0] bits;
    logic mwr;
  } chk_s;
  chk_s q, d;
  logic lid_exp;
  always_comb begin
    d = q;
    if (sa_strobe) begin
      d.hist = {q.hist[1:0], sa_bits[SA7_IDX]};
    end
    // saturate so a long run never wraps
    if (line_bit_en && q.bits != 18'h3FFFF) begin
      d.bits = q.bits + 18'h1;
    end
    if (psel && penable && pwrite && paddr == OFS_INT_MASK) begin
      d.mwr = 1'b1;
    end
    if (srst) begin
      d = '{hist: SA7_HIST_RST, bits: 18'h0, mwr: 1'b0};
    end
  end
  always_ff @(posedge clk) begin
    q <= d;
  end
  assign lid_exp = ~((q.hist[0] & q.hist[1]) | (q.hist[0] & q.hist[2]) | (q.hist[1] & q.hist[2]));
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence rd_setup;
    psel && !penable && !pwrite && paddr == OFS_STATUS;
  endsequence
  sequence rd_access;
    rd_setup ##1 (psel && penable);
  endsequence
  AST_PREADY: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("slave error outside access");
  AST_LINK: assert property (link_id_detected == lid_exp)
    else $error("link id differs from sa7 vote");
  AST_RED_DECL: assert property ($rose(red_alarm) |-> q.bits >= LIM)
    else $error("red alarm too early");
  AST_AIS_DECL: assert property ($rose(ais_alarm) |-> q.bits >= LIM)
    else $error("ais alarm too early");
  AST_RESET: assert property ($fell(srst) |-> !red_alarm && !ais_alarm && !link_id_detected && !irq)
    else $error("outputs not cleared by reset");
  AST_STATUS_RD: assert property (rd_access |-> prdata[2:0] == $past({ais_alarm, red_alarm, link_id_detected}))
    else $error("status read wrong");
  AST_IRQ_MASKED: assert property (!q.mwr |-> !irq)
    else $error("irq with reset mask");
endmodule
bind e1_national_bits_alarm_integrator nb_alarm_props u_props (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_bit_en(line_bit_en), .sa_strobe(sa_strobe),
  .sa_bits(sa_bits), .link_id_detected(link_id_detected), .red_alarm(red_alarm),
  .ais_alarm(ais_alarm), .irq(irq));

/* verif/framer_model.sv */
// behavioural receive framer feeding the block
`timescale 1ns/100ps
module framer_model
  import nb_alarm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // scenario control; oof_mode and ais_hits are taken at each interval end
  input wire logic [1:0] oof_mode,
  input wire logic [4:0] ais_hits,
  input wire logic go,
  input wire logic [19:0] sa_word,
  output logic ivl_end,
  // framer stream
  output logic line_bit_en,
  output logic all_ones_defect_detect,
  output logic frame_loss_indication,
  output logic sa_strobe,
  output logic [SA_COUNT-1:0] sa_bits,
  output logic [SA_POS_W-1:0] sa_pos,
  output logic submf_end
);
  logic [12:0] cnt;
  logic [1:0] oof_q;
  logic [4:0] hits_q;
  logic [2:0] ph;
  initial {line_bit_en, sa_strobe, submf_end, sa_bits, sa_pos, cnt, oof_q, hits_q, ph} = '0;
  assign ivl_end = line_bit_en && cnt == 13'h1FFF;
  assign all_ones_defect_detect = 5'(cnt[12:9]) < hits_q;
  // level or a lone one-cycle loss
  assign frame_loss_indication = oof_q == 2'h1 || (oof_q == 2'h2 && cnt == 13'h64);
  always @(posedge clk) begin
    sa_strobe <= 1'b0;
    submf_end <= 1'b0;
    // unqualified sa lines never repeat the last value
    sa_bits <= ~sa_bits;
    if (srst) begin
      {line_bit_en, cnt, oof_q, hits_q, ph} <= '0;
    end else begin
      line_bit_en <= 1'b1;
      if (line_bit_en) cnt <= cnt + 13'h1;
      if (ivl_end) begin
        oof_q <= oof_mode;
        hits_q <= ais_hits;
      end
      if (go) ph <= 3'h4;
      if (ph != 3'h0) begin
        sa_strobe <= 1'b1;
        sa_pos <= 2'(3'h4 - ph);
        submf_end <= ph == 3'h1;
        for (int i = 0; i < SA_COUNT; i++) sa_bits[i] <= sa_word[4*i-1+ph];
        ph <= ph - 3'h1;
      end
    end
  end
endmodule

/* verif/e1_national_bits_alarm_integrator_tb.sv */
// self-checking bench for the national-bit and alarm block
`timescale 1ns/100ps
module e1_national_bits_alarm_integrator_tb
  import nb_alarm_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, irq, lid, red, ais, ivl_end, lbe, aod, fli, sas, sme;
  logic [1:0] oof_mode = 2'h0, sa_pos;
  logic [4:0] ais_hits = 5'h0, sa_bits, red_e = 5'h0, ais_e = 5'h0;
  logic [19:0] sa_word = 20'h0, prev = 20'h0;
  int mismatches = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  e1_national_bits_alarm_integrator dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_bit_en(lbe), .all_ones_defect_detect(aod),
    .frame_loss_indication(fli), .sa_strobe(sas), .sa_bits(sa_bits), .sa_pos(sa_pos),
    .submf_end(sme), .link_id_detected(lid), .red_alarm(red), .ais_alarm(ais), .irq(irq));
  framer_model u_framer (.clk(clk), .srst(srst), .oof_mode(oof_mode), .ais_hits(ais_hits),
    .go(go), .sa_word(sa_word), .ivl_end(ivl_end), .line_bit_en(lbe),
    .all_ones_defect_detect(aod), .frame_loss_indication(fli), .sa_strobe(sas),
    .sa_bits(sa_bits), .sa_pos(sa_pos), .submf_end(sme));
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      summarize();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // answer and read data are taken at the rising edge that sees pready
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wait_ivl;
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (ivl_end !== 1'b1 && n < 9000);
    if (ivl_end !== 1'b1) begin
      mismatches++;
      summarize();
    end else begin
      @(posedge clk);
    end
  endtask
  function logic [4:0] step(input logic [4:0] c, input logic up);
    if (up) return (c == 5'(ALARM_INTERVALS)) ? c : c + 5'h1;
    return (c == 5'h0) ? c : c - 5'h1;
  endfunction
  initial begin
    logic [19:0] words [4];
    logic [1:0] om [6];
    logic [4:0] ah [6];
    void'($urandom(32'h84AD25EA));
    words = '{20'h00000, 20'hFFFFF, 20'(($urandom)), 20'(($urandom))};
    om = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0};
    ah = '{5'h0D, 5'h10, 5'h0C, 5'h0E, 5'($urandom_range(16)), 5'h00};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rchk(OFS_STATUS, 32'h0);
    rchk(OFS_INT_MASK, 32'h0);
    rchk(OFS_CTRL, 32'h1);
    rchk(OFS_COUNTS, 32'h0);
    apb(1'b1, OFS_STATUS, 32'h7);
    rchk(OFS_STATUS, 32'h0);
    rchk(8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    foreach (words[i]) begin
      apb(1'b1, OFS_INT_MASK, {31'h0, i != 0});
      sa_word <= words[i];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      rchk(OFS_NATBITS, {12'h0, prev});
      repeat (3) @(posedge clk);
      rchk(OFS_NATBITS, {12'h0, words[i]});
      rchk(OFS_STATUS, {31'h0, $countones(words[i][14:12]) < 2});
      chk({31'h0, lid}, {31'h0, $countones(words[i][14:12]) < 2});
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, i != 0});
      apb(1'b1, OFS_INT_STAT, 32'hF);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      prev = words[i];
    end
    $display("test natbits done");
    {oof_mode, ais_hits} <= {om[0], ah[0]};
    wait_ivl();
    rchk(OFS_COUNTS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      if (i < 5) {oof_mode, ais_hits} <= {om[i+1], ah[i+1]};
      wait_ivl();
      red_e = step(red_e, om[i] != 2'h0);
      ais_e = step(ais_e, ah[i] >= 5'(AIS_VALID_MIN));
      rchk(OFS_COUNTS, {19'h0, ais_e, 3'h0, red_e});
      chk({30'h0, ais, red}, 32'h0);
    end
    rchk(OFS_STATUS, {31'h0, $countones(prev[14:12]) < 2});
    apb(1'b1, OFS_CTRL, 32'h0);
    rchk(OFS_COUNTS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    $display("test intervals done");
    summarize();
  end
endmodule
